// ===== design/srbt_cfg.svh
// constants of the serial receive block terminator
`ifndef SRBT_CFG_SVH
`define SRBT_CFG_SVH
`define SRBT_AW 12
`define SRBT_PW 13
`define SRBT_BUF_BYTES 13'h1000
`define SRBT_BUF_LAST 13'h0fff
`define SRBT_PAGE_LAST 8'hff
`define SRBT_PAGE_LAST2 8'hfe
`define SRBT_TERM_MAX 12
`define SRBT_SEL_TERM 0
`define SRBT_SEL_MSG 1
`define SRBT_SEL_GAP 2
`define SRBT_SEL_LEN 3
`define SRBT_MS_NS 1000000
`define SRBT_CLK_NS 10
`define SRBT_TICK_CYC (`SRBT_MS_NS / `SRBT_CLK_NS)
`define SRBT_TICK_W 17
`define SRBT_MS_W 16
`endif

// ===== design/srbt_pkg.sv
// types of the serial receive block terminator
`default_nettype none
`include "srbt_cfg.svh"
package srbt_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_LO, ST_HI, ST_OUT} srbt_state_t;
	typedef logic [7:0] srbt_byte_t;
	typedef logic [`SRBT_PW-1:0] srbt_ptr_t;
	typedef logic [`SRBT_MS_W-1:0] srbt_ms_t;
endpackage
`default_nettype wire

// ===== design/srbt_mem_if.sv
// receive buffer port bundle
`timescale 1ns/1ps
`default_nettype none
`include "srbt_cfg.svh"
interface srbt_mem_if;
	logic wr_en;
	logic [`SRBT_AW-1:0] wr_addr;
	logic [7:0] wr_data;
	logic [`SRBT_AW-1:0] rd_addr;
	logic [7:0] rd_data;
	modport ctl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
	modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface
`default_nettype wire

// ===== design/srbt_mem.sv
// receive buffer memory with registered read
`timescale 1ns/1ps
`default_nettype none
`include "srbt_cfg.svh"
module srbt_mem
	import srbt_pkg::*;
(
	input wire logic clock,
	srbt_mem_if.mem bus
);
	srbt_byte_t ram [`SRBT_BUF_BYTES];

	always_ff @(posedge clock) begin
		if (bus.wr_en) begin
			ram[bus.wr_addr] <= bus.wr_data;
		end
	end

	always_ff @(posedge clock) begin
		bus.rd_data <= ram[bus.rd_addr];
	end
endmodule
`default_nettype wire

// ===== design/srbt_top.sv
// receive block terminator for one serial port
// Operation
// - select bits: term, timeout, gap, length
// - zero selection means streaming mode
// - streaming forwards each character at once
// - any combination of selection bits works
// - block ends after configured terminator character
// - message timer from first character closes
// - gap timer restarts per character, closes
// - fixed length closes block, remainder waits
// - receive buffer holds 4096 bytes
// - full buffer forces forwarding, no loss
// - delivery in pages of up to 256 bytes, a block end also ends the page
// - up to twelve terminators, count compared
// - gap timeout counted in milliseconds
// - optional byte swap of each word
`timescale 1ns/1ps
`default_nettype none
`include "srbt_cfg.svh"
module srbt_top
	import srbt_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = `SRBT_TICK_CYC
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic cfg_load,
	input wire logic [7:0] receive_end_condition_select,
	input wire logic [3:0] terminator_count,
	input wire logic [`SRBT_TERM_MAX-1:0][7:0] terminator_chars,
	input wire logic [`SRBT_PW-1:0] fixed_block_length,
	input wire logic [`SRBT_MS_W-1:0] message_timeout_ms,
	input wire logic [`SRBT_MS_W-1:0] char_gap_ms,
	input wire logic receive_byte_swap,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	output logic rx_ready,
	output logic out_valid,
	input wire logic out_ready,
	output logic [15:0] out_data,
	output logic out_two_bytes,
	output logic out_page_end,
	output logic out_block_end
);
	srbt_mem_if mif ();
	srbt_mem u_mem (.clock(clock), .bus(mif.mem));

	logic [7:0] sel_ff;
	logic [3:0] tcnt_ff;
	logic [`SRBT_TERM_MAX-1:0][7:0] tchar_ff;
	srbt_ptr_t len_ff;
	srbt_ms_t msg_lim_ff;
	srbt_ms_t gap_lim_ff;
	logic swap_ff;
	srbt_ptr_t wp_ff;
	srbt_ptr_t cp_ff;
	srbt_ptr_t rp_ff;
	srbt_ptr_t pending;
	srbt_ptr_t used;
	logic rx_fire;
	logic [`SRBT_TERM_MAX-1:0] term_hit;
	logic stream;
	logic len_hit;
	logic full_hit;
	logic commit_byte;
	logic msg_exp;
	logic gap_exp;
	logic commit_now;
	logic [`SRBT_TICK_W-1:0] tick_cnt_ff;
	logic tick;
	logic msg_run_ff;
	logic gap_run_ff;
	srbt_ms_t msg_ms_ff;
	srbt_ms_t gap_ms_ff;
	srbt_state_t state_ff;
	srbt_byte_t lo_ff;
	logic [7:0] page_cnt_ff;
	logic pend_ff;
	logic bend_ff;
	logic two_ff;
	logic [15:0] data_ff;

	// configuration captured on load, streaming after reset
	always_ff @(posedge clock) begin
		if (rst) begin
			sel_ff <= 8'h00;
			tcnt_ff <= 4'h0;
			tchar_ff <= '0;
			len_ff <= '0;
			msg_lim_ff <= '0;
			gap_lim_ff <= '0;
			swap_ff <= 1'b0;
		end else if (cfg_load) begin
			sel_ff <= receive_end_condition_select;
			tcnt_ff <= terminator_count;
			tchar_ff <= terminator_chars;
			len_ff <= fixed_block_length;
			msg_lim_ff <= message_timeout_ms;
			gap_lim_ff <= char_gap_ms;
			swap_ff <= receive_byte_swap;
		end
	end

	assign pending = wp_ff - cp_ff;
	assign used = wp_ff - rp_ff;
	assign rx_ready = (used != `SRBT_BUF_BYTES);
	assign rx_fire = rx_valid && rx_ready;

	for (genvar i = 0; i < `SRBT_TERM_MAX; i++) begin : g_term
		assign term_hit[i] = (4'(i) < tcnt_ff) && (rx_data == tchar_ff[i]);
	end

	assign stream = (sel_ff[`SRBT_SEL_LEN:`SRBT_SEL_TERM] == 4'h0);
	assign len_hit = sel_ff[`SRBT_SEL_LEN] && (len_ff != '0) && (pending + 13'h1 == len_ff);
	assign full_hit = (pending == `SRBT_BUF_LAST);
	assign commit_byte = rx_fire && (stream || (sel_ff[`SRBT_SEL_TERM] && (|term_hit))
		|| len_hit || full_hit);
	assign msg_exp = sel_ff[`SRBT_SEL_MSG] && msg_run_ff && (msg_ms_ff >= msg_lim_ff);
	assign gap_exp = sel_ff[`SRBT_SEL_GAP] && gap_run_ff && (gap_ms_ff >= gap_lim_ff);
	assign commit_now = commit_byte || msg_exp || gap_exp;

	always_ff @(posedge clock) begin
		if (rst) begin
			wp_ff <= '0;
		end else if (rx_fire) begin
			wp_ff <= wp_ff + 13'h1;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			cp_ff <= '0;
		end else if (commit_now) begin
			cp_ff <= rx_fire ? wp_ff + 13'h1 : wp_ff;
		end
	end

	assign mif.wr_en = rx_fire;
	assign mif.wr_addr = wp_ff[`SRBT_AW-1:0];
	assign mif.wr_data = rx_data;

	// millisecond time base
	assign tick = (tick_cnt_ff == `SRBT_TICK_W'(TICK_CYCLES - 1));
	always_ff @(posedge clock) begin
		if (rst || tick) begin
			tick_cnt_ff <= '0;
		end else begin
			tick_cnt_ff <= tick_cnt_ff + 1'b1;
		end
	end

	// message timer starts on first character
	always_ff @(posedge clock) begin
		if (rst || commit_now) begin
			msg_run_ff <= 1'b0;
			msg_ms_ff <= '0;
		end else begin
			if (rx_fire && sel_ff[`SRBT_SEL_MSG]) begin
				msg_run_ff <= 1'b1;
			end
			if (msg_run_ff && tick) begin
				msg_ms_ff <= msg_ms_ff + 1'b1;
			end
		end
	end

	// gap timer restarted by each character
	always_ff @(posedge clock) begin
		if (rst || commit_now) begin
			gap_run_ff <= 1'b0;
			gap_ms_ff <= '0;
		end else if (rx_fire) begin
			gap_run_ff <= sel_ff[`SRBT_SEL_GAP];
			gap_ms_ff <= '0;
		end else if (gap_run_ff && tick) begin
			gap_ms_ff <= gap_ms_ff + 1'b1;
		end
	end

	// delivery reads
	always_comb begin
		mif.rd_addr = rp_ff[`SRBT_AW-1:0];
		if (state_ff == ST_LO) begin
			mif.rd_addr = rp_ff[`SRBT_AW-1:0] + 12'h1;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state_ff <= ST_IDLE;
			rp_ff <= '0;
			lo_ff <= 8'h00;
			page_cnt_ff <= 8'h00;
			pend_ff <= 1'b0;
			bend_ff <= 1'b0;
			two_ff <= 1'b0;
			data_ff <= 16'h0000;
		end else begin
			unique case (state_ff)
				ST_IDLE: begin
					if (rp_ff != cp_ff) begin
						state_ff <= ST_LO;
					end
				end
				ST_LO: begin
					lo_ff <= mif.rd_data;
					if ((rp_ff + 13'h1 != cp_ff) && (page_cnt_ff != `SRBT_PAGE_LAST)) begin
						state_ff <= ST_HI;
					end else begin
						two_ff <= 1'b0;
						bend_ff <= (rp_ff + 13'h1 == cp_ff);
						pend_ff <= (rp_ff + 13'h1 == cp_ff) || (page_cnt_ff == `SRBT_PAGE_LAST);
						data_ff <= swap_ff ? {mif.rd_data, 8'h00} : {8'h00, mif.rd_data};
						state_ff <= ST_OUT;
					end
				end
				ST_HI: begin
					two_ff <= 1'b1;
					bend_ff <= (rp_ff + 13'h2 == cp_ff);
					pend_ff <= (rp_ff + 13'h2 == cp_ff) || (page_cnt_ff == `SRBT_PAGE_LAST2);
					data_ff <= swap_ff ? {lo_ff, mif.rd_data} : {mif.rd_data, lo_ff};
					state_ff <= ST_OUT;
				end
				ST_OUT: begin
					if (out_ready) begin
						rp_ff <= rp_ff + (two_ff ? 13'h2 : 13'h1);
						page_cnt_ff <= pend_ff ? 8'h00 : page_cnt_ff + (two_ff ? 8'h2 : 8'h1);
						state_ff <= ST_IDLE;
					end
				end
			endcase
		end
	end

	assign out_valid = (state_ff == ST_OUT);
	assign out_data = data_ff;
	assign out_two_bytes = two_ff;
	assign out_page_end = pend_ff;
	assign out_block_end = bend_ff;

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	property p_stream;
		rx_fire && stream |=> (cp_ff == wp_ff);
	endproperty
	a_stream: assert property (p_stream) else $error("stream byte not released");

	property p_hold;
		rx_fire && !commit_now |=> (cp_ff == $past(cp_ff)) && (wp_ff == $past(wp_ff) + 13'h1);
	endproperty
	a_hold: assert property (p_hold) else $error("block released early");

	property p_term;
		rx_fire && sel_ff[`SRBT_SEL_TERM] && (|term_hit) |=> (pending == '0);
	endproperty
	a_term: assert property (p_term) else $error("terminator did not close block");

	property p_msg;
		msg_exp && !rx_fire |=> (pending == '0) && !msg_run_ff;
	endproperty
	a_msg: assert property (p_msg) else $error("message timeout did not close");

	property p_gap;
		gap_run_ff && rx_fire |=> (gap_ms_ff == '0);
	endproperty
	a_gap: assert property (p_gap) else $error("gap timer not restarted");

	property p_len;
		rx_fire && len_hit |=> (pending == '0) ##0 ($past(pending) + 13'h1 == len_ff);
	endproperty
	a_len: assert property (p_len) else $error("length close wrong");

	property p_cap;
		(used <= `SRBT_BUF_BYTES) && (pending <= used);
	endproperty
	a_cap: assert property (p_cap) else $error("buffer pointers overran capacity");

	property p_full;
		rx_fire && full_hit |=> (pending == '0);
	endproperty
	a_full: assert property (p_full) else $error("full buffer not forwarded");

	property p_page;
		out_valid && !out_page_end |-> (page_cnt_ff < `SRBT_PAGE_LAST2) || !two_ff;
	endproperty
	a_page: assert property (p_page) else $error("page exceeds limit");

	property p_tcnt;
		(tcnt_ff == 4'h0) |-> (term_hit == '0);
	endproperty
	a_tcnt: assert property (p_tcnt) else $error("unused terminator compared");

	property p_restart;
		commit_now |=> !msg_run_ff && (msg_ms_ff == '0) && (gap_ms_ff == '0);
	endproperty
	a_restart: assert property (p_restart) else $error("timers not restarted");

	c_stream: cover property (rx_fire && stream);
	c_term: cover property (rx_fire && sel_ff[`SRBT_SEL_TERM] && (|term_hit));
	c_gap: cover property (gap_exp);
	c_page: cover property (out_valid && out_ready && out_page_end && !out_block_end);
endmodule
`default_nettype wire

// ===== dv/srbt_dev_model.sv
// serial field device feeding characters into the block
`timescale 1ns/1ps
`default_nettype none
module srbt_dev_model (
	input wire logic clock,
	input wire logic rx_ready,
	output logic rx_valid,
	output logic [7:0] rx_data
);
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h5a;
	end
	// called just after an edge; holds the byte until taken, then idles gap+1 edges
	task automatic put(input logic [7:0] b, input int gap);
		logic r;
		rx_valid = 1'b1;
		rx_data = b;
		do begin
			r = rx_ready;
			@(posedge clock);
			#1;
		end while (r !== 1'b1);
		rx_valid = 1'b0;
		rx_data = ~b;
		repeat (gap + 1) @(posedge clock);
		#1;
	endtask
endmodule
`default_nettype wire

// ===== dv/tb.sv
// self-checking bench of the receive block terminator
`timescale 1ns/1ps
`default_nettype none
module tb;
	import srbt_pkg::*;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic cfg_load = 1'b0;
	logic [7:0] sel = 8'h00;
	logic [3:0] tcnt = 4'h2;
	logic [11:0][7:0] tchr = {72'h0, 8'h44, 8'h0a, 8'h0d};
	logic [12:0] blen = 13'h0;
	logic [15:0] tmo = 16'h0;
	logic [15:0] gapms = 16'h0;
	logic swap = 1'b0;
	logic out_ready = 1'b1;
	logic rx_valid, rx_ready, out_valid, out_two_bytes, out_page_end, out_block_end;
	logic [7:0] rx_data;
	logic [15:0] out_data;
	logic [7:0] got[$];
	logic swp = 1'b0;
	int pg, bk, fails, num_checks;
	srbt_top #(.TICK_CYCLES(10)) dut (.clock(clock), .rst(rst), .cfg_load(cfg_load),
		.receive_end_condition_select(sel), .terminator_count(tcnt),
		.terminator_chars(tchr), .fixed_block_length(blen), .message_timeout_ms(tmo),
		.char_gap_ms(gapms), .receive_byte_swap(swap), .rx_valid(rx_valid),
		.rx_data(rx_data), .rx_ready(rx_ready), .out_valid(out_valid),
		.out_ready(out_ready), .out_data(out_data), .out_two_bytes(out_two_bytes),
		.out_page_end(out_page_end), .out_block_end(out_block_end));
	srbt_dev_model dev (.clock(clock), .rx_ready(rx_ready), .rx_valid(rx_valid),
		.rx_data(rx_data));
	initial begin
		forever #5 clock = ~clock;
	end
	always @(posedge clock) begin
		if (out_valid === 1'b1 && out_ready === 1'b1) begin
			got.push_back(swp ? out_data[15:8] : out_data[7:0]);
			if (out_two_bytes === 1'b1) got.push_back(swp ? out_data[7:0] : out_data[15:8]);
			pg += int'(out_page_end === 1'b1);
			bk += int'(out_block_end === 1'b1);
		end
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic check(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("ERROR at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic check_q(input logic [7:0] e[$]);
		check(got.size(), e.size());
		foreach (e[i]) if (i < got.size()) check(got[i], e[i]);
	endtask
	task automatic setup(input logic [7:0] s, input logic [12:0] l, input logic [15:0] t,
		input logic [15:0] g, input logic w);
		rst = 1'b1;
		cyc(2);
		rst = 1'b0;
		{sel, blen, tmo, gapms, swap} = {s, l, t, g, w};
		cfg_load = 1'b1;
		cyc(1);
		cfg_load = 1'b0;
		got.delete();
		{pg, bk, swp} = {32'h0, 32'h0, w};
	endtask
	task automatic s_stream;
		setup(8'hf0, 13'h0, 16'h0, 16'h0, 1'b0);
		dev.put(8'h31, 8);
		check_q({8'h31});
		check(bk, 1);
	endtask
	task automatic s_term;
		setup(8'h01, 13'h0, 16'h0, 16'h0, 1'b0);
		dev.put(8'h41, 0);
		dev.put(8'h42, 0);
		dev.put(8'h0d, 0);
		dev.put(8'h44, 0);
		dev.put(8'h45, 20);
		check_q({8'h41, 8'h42, 8'h0d});
		dev.put(8'h0a, 20);
		check_q({8'h41, 8'h42, 8'h0d, 8'h44, 8'h45, 8'h0a});
	endtask
	task automatic s_len;
		logic [7:0] e[$];
		setup(8'h08, 13'h3, 16'h0, 16'h0, 1'b1);
		for (int i = 0; i < 10; i++) dev.put(8'h50 + 8'(i), 0);
		for (int i = 0; i < 9; i++) e.push_back(8'h50 + 8'(i));
		cyc(30);
		check_q(e);
	endtask
	task automatic s_gap;
		setup(8'h04, 13'h0, 16'h0, 16'h2, 1'b0);
		for (int i = 0; i < 3; i++) dev.put(8'h61 + 8'(i), 4);
		cyc(5);
		check(got.size(), 0);
		cyc(30);
		check_q({8'h61, 8'h62, 8'h63});
	endtask
	task automatic s_msg;
		setup(8'h06, 13'h0, 16'h3, 16'ha, 1'b0);
		dev.put(8'h71, 0);
		dev.put(8'h72, 10);
		check(got.size(), 0);
		cyc(30);
		check_q({8'h71, 8'h72});
		check(bk, 1);
		dev.put(8'h73, 0);
		dev.put(8'h74, 10);
		check(got.size(), 2);
		cyc(30);
		check_q({8'h71, 8'h72, 8'h73, 8'h74});
		check(bk, 2);
	endtask
	task automatic s_full;
		tcnt = 4'h0;
		setup(8'h01, 13'h0, 16'h0, 16'h0, 1'b0);
		out_ready = 1'b0;
		for (int i = 0; i < 4096; i++) dev.put(8'(i), 0);
		cyc(2);
		check(rx_ready, 0);
		out_ready = 1'b1;
		cyc(9000);
		check(got.size(), 4096);
		check(got[4095], 8'hff);
		check(pg, 16);
		check(bk, 1);
		dev.put(8'h77, 20);
		check(got.size(), 4096);
	endtask
	task automatic print_verdict;
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		#400000;
		fails++;
		print_verdict();
	end
	initial begin
		cyc(6);
		s_stream();
		s_term();
		s_len();
		s_gap();
		s_msg();
		s_full();
		print_verdict();
	end
endmodule
`default_nettype wire
